// *** bench/tb.sv ***
// Self checking bench for the user sense and enable pin block.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        hclk    = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel    = 1'b0;
   logic [31:0] haddr   = 32'h0;
   logic [1:0]  htrans  = 2'h0;
   logic        hwrite  = 1'b0;
   logic [2:0]  hsize   = 3'h2;
   logic [31:0] hwdata  = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        s0;
   logic        s1;
   logic        e0;
   logic        e1;
   logic        run_mode;
   logic        irq;
   int          error_cnt   = 0;
   int          checks_done = 0;
   always #2 hclk = ~hclk;
   usep_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .sense_input_0(s0), .sense_input_1(s1),
      .enable_output_0(e0), .enable_output_1(e1), .run_mode(run_mode), .irq(irq));
   usep_user_model u_user (.hclk(hclk), .enable_output_0(e0), .enable_output_1(e1),
      .sense_input_0(s0), .sense_input_1(s1));
   task wrap_up;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : wrap_up
   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   // Ready is looked at in the second half of a cycle, then the edge is taken.
   task wait_rdy;
      int n;
      n = 0;
      do begin
         @(negedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 100);
      if (hreadyout !== 1'b1) begin
         error_cnt++;
         $display("ERROR at %0t: bus wait timed out", $time);
         wrap_up();
      end
   endtask : wait_rdy
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= w;
      hsize  <= usep_pkg::HSIZE_WORD;
      wait_rdy();
      @(posedge hclk);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      r = hrdata;
      chk({31'h0, hresp}, 32'h0, "bus response");
   endtask : bus
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
      @(posedge hclk);
      @(negedge hclk);
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(r, exp, what);
   endtask : rd
   task t_reset;
      @(negedge hclk);
      chk({28'h0, run_mode, irq, e1, e0}, 32'h0, "pins after reset");
      for (int i = 0; i < 5; i++) rd(8'(i * 4), 32'h0, "reg after reset");
      rd(8'h40, 32'h0, "unmapped read");
      $display("test reset done");
   endtask : t_reset
   task t_enable;
      for (int v = 0; v < 4; v++) begin
         wr(usep_pkg::OFF_USER, 32'(v << 2));
         chk({30'h0, u_user.en_seen}, 32'(v), "enable pins");
         rd(usep_pkg::OFF_USER, 32'(v << 2), "user reg");
      end
      wr(usep_pkg::OFF_USER, 32'h0);
      $display("test enable done");
   endtask : t_enable
   task t_sense(input int idx);
      logic [31:0] b;
      b = 32'h1 << idx;
      // One cycle short of the minimum time, so it must leave no trace.
      u_user.pulse(idx, 39);
      repeat (10) @(posedge hclk);
      rd(usep_pkg::OFF_USER, 32'h0, "short pulse");
      rd(usep_pkg::OFF_IRQ_STAT, 32'h0, "short pulse status");
      wr(usep_pkg::OFF_IRQ_EN, b);
      // Exactly the minimum time must set the flag.
      u_user.pulse(idx, 40);
      repeat (10) @(posedge hclk);
      rd(usep_pkg::OFF_USER, b, "sticky flag");
      rd(usep_pkg::OFF_IRQ_STAT, b, "irq status");
      chk({31'h0, irq}, 32'h1, "irq raised");
      wr(usep_pkg::OFF_IRQ_EN, 32'h0);
      chk({31'h0, irq}, 32'h0, "irq masked");
      wr(usep_pkg::OFF_IRQ_EN, b);
      wr(usep_pkg::OFF_USER, b);
      rd(usep_pkg::OFF_USER, 32'h0, "flag cleared");
      chk({31'h0, irq}, 32'h1, "irq kept");
      wr(usep_pkg::OFF_IRQ_CLR, b);
      chk({31'h0, irq}, 32'h0, "irq cleared");
      rd(usep_pkg::OFF_IRQ_STAT, 32'h0, "status cleared");
      wr(usep_pkg::OFF_IRQ_EN, 32'h0);
      $display("test sense %0d done", idx);
   endtask : t_sense
   task t_rerst;
      wr(usep_pkg::OFF_MODE, 32'h1);
      chk({31'h0, run_mode}, 32'h1, "run mode");
      wr(usep_pkg::OFF_USER, 32'hc);
      wr(usep_pkg::OFF_IRQ_EN, 32'h3);
      @(posedge hclk);
      hresetn <= 1'b0;
      @(negedge hclk);
      chk({29'h0, run_mode, e1, e0}, 32'h0, "pins in reset");
      // Reset is held well past one edge, as outside logic must do.
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 5; i++) rd(8'(i * 4), 32'h0, "reg after reset");
      $display("test second reset done");
   endtask : t_rerst
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_enable();
      t_sense(0);
      t_sense(1);
      t_rerst();
      wrap_up();
   end
endmodule : tb

// *** bench/usep_user_model.sv ***
// Far side user logic that drives the sense pins and watches the enable pins.
module usep_user_model (
   // Clock
   input  wire logic hclk,
   // User pins
   input  wire logic enable_output_0,
   input  wire logic enable_output_1,
   output logic      sense_input_0,
   output logic      sense_input_1
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] pin_q = 2'h0;
   logic [1:0] en_seen;
   // What the outside logic sees on the enable pins.
   assign en_seen = {enable_output_1, enable_output_0};
   assign sense_input_0 = pin_q[0];
   assign sense_input_1 = pin_q[1];
   // Levels change just after an edge, so the device never sees a half cycle.
   task pulse(input int idx, input int n);
      @(posedge hclk);
      pin_q[idx] <= 1'b1;
      repeat (n) @(posedge hclk);
      pin_q[idx] <= 1'b0;
   endtask : pulse
endmodule : usep_user_model

// *** rtl/usep_ahb_slv.sv ***
// AHB-Lite slave front end: zero wait writes, one wait state reads.
module usep_ahb_slv (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // Bus request
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   // Bus answer
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Register side
   usep_reg_if.slave        rif
);
   logic        act;
   logic        wr_q,   wr_d;
   logic        rd_q,   rd_d;
   logic [7:0]  addr_q, addr_d;
   logic [31:0] rdat_q, rdat_d;

   // Non-word sizes are taken as transfers but touch nothing.
   always_comb begin
      act    = hsel && htrans[1] && hready && (hsize == usep_pkg::HSIZE_WORD);
      wr_d   = act && hwrite;
      rd_d   = act && !hwrite;
      addr_d = act ? {haddr[7:2], 2'h0} : addr_q;
      rdat_d = rd_q ? rif.rdata : rdat_q;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q   <= 1'b0;
         rd_q   <= 1'b0;
         addr_q <= 8'h00;
         rdat_q <= 32'h0;
      end else begin
         wr_q   <= wr_d;
         rd_q   <= rd_d;
         addr_q <= addr_d;
         rdat_q <= rdat_d;
      end
   end

   assign rif.wr_en  = wr_q;
   assign rif.addr   = addr_q;
   assign rif.wdata  = hwdata;
   assign hrdata     = rdat_q;
   assign hreadyout  = !rd_q;
   assign hresp      = 1'b0;

   read_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_q |-> !hreadyout ##1 hreadyout)
      else $error("Read data phase is not exactly one wait state.");
endmodule : usep_ahb_slv

// *** rtl/usep_pkg.sv ***
// Constants shared by the user sense and enable pin block.
package usep_pkg;
   // Register byte offsets on the word aligned bus.
   localparam logic [7:0] OFF_MODE     = 8'h00;
   localparam logic [7:0] OFF_USER     = 8'h04;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
   localparam logic [7:0] OFF_IRQ_CLR  = 8'h0c;
   localparam logic [7:0] OFF_IRQ_EN   = 8'h10;

   // Field positions.
   localparam int unsigned MODE_RUN_BIT   = 0;
   localparam int unsigned USER_SENSE_LSB = 0;
   localparam int unsigned USER_EN_LSB    = 2;
   localparam int unsigned PIN_N          = 2;

   // Reset values.
   localparam logic             MODE_RST  = 1'b0;
   localparam logic [PIN_N-1:0] SENSE_RST = 2'h0;
   localparam logic [PIN_N-1:0] EN_RST    = 2'h0;
   localparam logic [PIN_N-1:0] IRQ_RST   = 2'h0;

   // Bus constants.
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   // Least time a sense input must stay asserted, rounded up to cycles.
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned SENSE_MIN_NS  = 160;
   localparam int unsigned SENSE_CYC     = (SENSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : usep_pkg

// *** rtl/usep_reg_if.sv ***
// Register access path from the bus slave to the register file.
interface usep_reg_if;
   logic        wr_en;
   logic [7:0]  addr;
   logic [31:0] wdata;
   logic [31:0] rdata;

   modport slave (
      output wr_en,
      output addr,
      output wdata,
      input  rdata
   );
   modport regs (
      input  wr_en,
      input  addr,
      input  wdata,
      output rdata
   );
endinterface : usep_reg_if

// *** rtl/usep_sense_filt.sv ***
// Sense pin synchroniser and minimum assertion time filter.
module usep_sense_filt #(
   parameter int unsigned CYC = usep_pkg::SENSE_CYC
) (
   // Clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // Pin and detection pulse
   input  wire logic pin,
   output logic      hit
);
   localparam int unsigned CW = $clog2(CYC + 1);

   logic          meta_q, meta_d;
   logic          sync_q, sync_d;
   logic [CW-1:0] cnt_q,  cnt_d;
   logic          hit_q,  hit_d;

   always_comb begin
      meta_d = pin;
      sync_d = meta_q;
      cnt_d  = cnt_q;
      hit_d  = 1'b0;
      // RULE10 consecutive cycle count.
      if (!sync_q) begin
         cnt_d = '0;
      end else if (cnt_q < CW'(CYC)) begin
         cnt_d = cnt_q + 1'b1;
         hit_d = (cnt_q == CW'(CYC - 1));
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         cnt_q  <= '0;
         hit_q  <= 1'b0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
         cnt_q  <= cnt_d;
         hit_q  <= hit_d;
      end
   end

   assign hit = hit_q;

   // One pulse per assertion, only after the full count.
   hit_count_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE10
      hit_q |-> (cnt_q == CW'(CYC)) && $past(sync_q))
      else $error("Sense hit without full assertion count.");
   glitch_drop_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE10
      !sync_q |=> !hit_q ##1 !hit_q)
      else $error("Sense hit after a deasserted sample.");
   hit_once_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE10
      hit_q |=> !hit_q)
      else $error("Sense hit lasted more than one cycle.");
endmodule : usep_sense_filt

// *** rtl/usep_top.sv ***
// User sense and enable pins with mode, user and interrupt registers.
// Summary of operation
// RULE1 - Reset low clears every software visible register.
// RULE2 - Reset forces the mode run bit to zero, meaning stop mode.
// RULE3 - Outside logic holds reset long enough and waits before use.
// RULE4 - Sense flag zero sets after sense input zero stays high 160 ns.
// RULE5 - Sense flag one sets after sense input one stays high 160 ns.
// RULE6 - Sense flag zero stays set until a bus write clears it.
// RULE7 - Sense flag one stays set until a bus write clears it.
// RULE8 - Enable output zero follows enable flag zero.
// RULE9 - Enable output one follows enable flag one.
// RULE10 - Sense inputs are synchronised and asserted cycles counted.
// RULE11 - A new sense flag is an interrupt event naming its input.
//
// Design decisions made here: the AHB-Lite interface to the registers and the address map.
module usep_top (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // Bus request
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   // Bus answer
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // User pins
   input  wire logic        sense_input_0,
   input  wire logic        sense_input_1,
   output logic             enable_output_0,
   output logic             enable_output_1,
   // Status
   output logic             run_mode,
   output logic             irq
);
   localparam int unsigned N = usep_pkg::PIN_N;

   usep_reg_if rif ();

   logic [N-1:0] pin;
   logic [N-1:0] hit;
   logic         wr_mode;
   logic         wr_user;
   logic         wr_iclr;
   logic         wr_ien;
   logic [N-1:0] w_sense;
   logic [N-1:0] w_en;
   logic         mode_q,  mode_d;
   logic [N-1:0] sense_q, sense_d;
   logic [N-1:0] en_q,    en_d;
   logic [N-1:0] ist_q,   ist_d;
   logic [N-1:0] ien_q,   ien_d;
   logic         first_q;

   usep_ahb_slv u_slv (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hready    (hready),
      .hwdata    (hwdata),
      .hrdata    (hrdata),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .rif       (rif.slave)
   );

   assign pin = {sense_input_1, sense_input_0};

   // RULE10 one filter per sense input.
   for (genvar i = 0; i < N; i++) begin : g_sense
      usep_sense_filt #(
         .CYC (usep_pkg::SENSE_CYC)
      ) u_filt (
         .hclk    (hclk),
         .hresetn (hresetn),
         .pin     (pin[i]),
         .hit     (hit[i])
      );
   end

   // Write decode; the clear register is write only and reads zero.
   always_comb begin
      wr_mode = rif.wr_en && (rif.addr == usep_pkg::OFF_MODE);
      wr_user = rif.wr_en && (rif.addr == usep_pkg::OFF_USER);
      wr_iclr = rif.wr_en && (rif.addr == usep_pkg::OFF_IRQ_CLR);
      wr_ien  = rif.wr_en && (rif.addr == usep_pkg::OFF_IRQ_EN);
      w_sense = rif.wdata[usep_pkg::USER_SENSE_LSB +: N];
      w_en    = rif.wdata[usep_pkg::USER_EN_LSB +: N];
   end

   // Mode register.
   always_comb begin
      mode_d = mode_q;
      if (wr_mode) begin
         mode_d = rif.wdata[usep_pkg::MODE_RUN_BIT];
      end
   end

   // RULE2 stop mode at reset.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_q <= usep_pkg::MODE_RST;
      end else begin
         mode_q <= mode_d;
      end
   end

   // Sense flags: writing one clears, a hit in the same cycle still sets.
   always_comb begin
      sense_d = sense_q;
      // RULE6 RULE7 clear only by write.
      if (wr_user) begin
         sense_d = sense_q & ~w_sense;
      end
      // RULE4 RULE5 set on detection.
      sense_d = sense_d | hit;
   end

   // Enable flags.
   always_comb begin
      en_d = en_q;
      if (wr_user) begin
         en_d = w_en;
      end
   end

   // RULE1 user register cleared at reset.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sense_q <= usep_pkg::SENSE_RST;
         en_q    <= usep_pkg::EN_RST;
      end else begin
         sense_q <= sense_d;
         en_q    <= en_d;
      end
   end

   // Interrupt status is kept apart from the flags so the handler can
   // acknowledge the event without losing the record of it.
   always_comb begin
      ist_d = ist_q;
      ien_d = ien_q;
      if (wr_iclr) begin
         ist_d = ist_q & ~rif.wdata[N-1:0];
      end
      // RULE11 event per sense input.
      ist_d = ist_d | hit;
      if (wr_ien) begin
         ien_d = rif.wdata[N-1:0];
      end
   end

   // RULE1 interrupt registers cleared at reset.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ist_q <= usep_pkg::IRQ_RST;
         ien_q <= usep_pkg::IRQ_RST;
      end else begin
         ist_q <= ist_d;
         ien_q <= ien_d;
      end
   end

   // Read mux; unmapped words read zero.
   always_comb begin
      unique case (rif.addr)
         usep_pkg::OFF_MODE: begin
            rif.rdata = {31'h0, mode_q};
         end
         usep_pkg::OFF_USER: begin
            rif.rdata = {28'h0, en_q, sense_q};
         end
         usep_pkg::OFF_IRQ_STAT: begin
            rif.rdata = {30'h0, ist_q};
         end
         usep_pkg::OFF_IRQ_EN: begin
            rif.rdata = {30'h0, ien_q};
         end
         default: begin
            rif.rdata = 32'h0;
         end
      endcase
   end

   // RULE8 RULE9 pins follow the flags.
   assign enable_output_0 = en_q[0];
   assign enable_output_1 = en_q[1];
   assign run_mode        = mode_q;
   assign irq             = |(ist_q & ien_q);

   // Marks the first edge after reset release for the checks below.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         first_q <= 1'b1;
      end else begin
         first_q <= 1'b0;
      end
   end

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_user_wr(int unsigned b);
      wr_user && rif.wdata[b];
   endsequence

   sequence s_iclr_wr(int unsigned b);
      wr_iclr && rif.wdata[b];
   endsequence

   sequence s_irq_cause(int unsigned b);
      hit[b] && ien_q[b] && !wr_ien;
   endsequence

   sequence s_flag_up(int unsigned b);
      hit[b] ##1 sense_q[b] && ist_q[b];
   endsequence

   // RULE1 RULE2 state after reset.
   reset_clear_a: assert property (first_q |-> // RULE1
      (sense_q == 2'h0) && (en_q == 2'h0) && (ist_q == 2'h0) && (ien_q == 2'h0) && !irq)
      else $error("Registers not cleared by reset.");

   stop_mode_a: assert property (first_q |-> !mode_q && !run_mode) // RULE2
      else $error("Mode run bit not zero after reset.");

   // Run bit follows writes only.
   mode_write_a: assert property (wr_mode |=> run_mode == $past(rif.wdata[usep_pkg::MODE_RUN_BIT]))
      else $error("Run bit does not follow its write.");

   mode_hold_a: assert property (!wr_mode |=> $stable(run_mode))
      else $error("Run bit moved without a write.");

   // RULE4 RULE5 flags set.
   sense0_set_a: assert property (hit[0] |-> s_flag_up(0)) // RULE4
      else $error("Sense flag zero did not set.");

   sense1_set_a: assert property (hit[1] |-> s_flag_up(1)) // RULE5
      else $error("Sense flag one did not set.");

   sense0_quiet_a: assert property (!sense_q[0] && !hit[0] |=> !sense_q[0]) // RULE4
      else $error("Sense flag zero set without a detection.");

   sense1_quiet_a: assert property (!sense_q[1] && !hit[1] |=> !sense_q[1]) // RULE5
      else $error("Sense flag one set without a detection.");

   // RULE6 RULE7 flags sticky.
   sense0_hold_a: assert property (sense_q[0] && !(wr_user && rif.wdata[0]) |=> sense_q[0]) // RULE6
      else $error("Sense flag zero dropped without a clear.");

   sense1_hold_a: assert property (sense_q[1] && !(wr_user && rif.wdata[1]) |=> sense_q[1]) // RULE7
      else $error("Sense flag one dropped without a clear.");

   sense_clear_a: assert property (s_user_wr(0) ##0 !hit[0] |=> !sense_q[0]) // RULE6
      else $error("Sense flag zero not cleared by write.");

   sense1_clear_a: assert property (s_user_wr(1) ##0 !hit[1] |=> !sense_q[1]) // RULE7
      else $error("Sense flag one not cleared by write.");

   // RULE8 RULE9 enable pins.
   enable0_pin_a: assert property (wr_user |=> enable_output_0 == $past(rif.wdata[2])) // RULE8
      else $error("Enable output zero does not follow its flag.");

   enable1_pin_a: assert property (wr_user |=> enable_output_1 == $past(rif.wdata[3])) // RULE9
      else $error("Enable output one does not follow its flag.");

   enable0_hold_a: assert property (!wr_user |=> $stable(enable_output_0)) // RULE8
      else $error("Enable output zero moved without a write.");

   enable1_hold_a: assert property (!wr_user |=> $stable(enable_output_1)) // RULE9
      else $error("Enable output one moved without a write.");

   // RULE11 interrupt events.
   irq_event_a: assert property (s_irq_cause(0) |=> irq) // RULE11
      else $error("Enabled sense event raised no interrupt.");

   irq1_event_a: assert property (s_irq_cause(1) |=> irq) // RULE11
      else $error("Enabled sense event one raised no interrupt.");

   irq_clear_a: assert property (s_iclr_wr(0) ##0 !hit[0] |=> !ist_q[0]) // RULE11
      else $error("Interrupt status zero not cleared by write.");

   irq1_clear_a: assert property (s_iclr_wr(1) ##0 !hit[1] |=> !ist_q[1]) // RULE11
      else $error("Interrupt status one not cleared by write.");

   irq_hold_a: assert property (ist_q[0] && !(wr_iclr && rif.wdata[0]) |=> ist_q[0]) // RULE11
      else $error("Interrupt status zero dropped without a clear.");

   irq1_hold_a: assert property (ist_q[1] && !(wr_iclr && rif.wdata[1]) |=> ist_q[1]) // RULE11
      else $error("Interrupt status one dropped without a clear.");

   ien_write_a: assert property (wr_ien |=> ien_q == $past(rif.wdata[N-1:0])) // RULE11
      else $error("Interrupt enable does not follow its write.");
endmodule : usep_top
